// ===== cwlp_map.svh
// Register offsets, field positions, reset values and codes for the window limit and
// peak tracking block.
// Assumes an 8-bit register address space and 12-bit conversion codes.
`ifndef CWLP_MAP_SVH
`define CWLP_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CWLP_ADDR_CH6_LOW_NIB_DEB 8'h3a
`define CWLP_ADDR_CH6_LOW_BYTE 8'h3b
`define CWLP_ADDR_CH7_HIGH_NIB_MARGIN 8'h3c
`define CWLP_ADDR_CH7_HIGH_BYTE 8'h3d
`define CWLP_ADDR_CH7_LOW_NIB_DEB 8'h3e
`define CWLP_ADDR_CH7_LOW_BYTE 8'h3f
`define CWLP_ADDR_CH0_PEAK_LOW 8'h60
`define CWLP_ADDR_CH0_PEAK_HIGH 8'h61
`define CWLP_ADDR_CH1_PEAK_LOW 8'h62
`define CWLP_ADDR_CH1_PEAK_HIGH 8'h63

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CWLP_NIB_MSB 7
`define CWLP_NIB_LSB 4
`define CWLP_FIELD_MSB 3
`define CWLP_FIELD_LSB 0
`define CWLP_MARGIN_SHIFT 3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CWLP_RST_HIGH_NIB 4'hf
`define CWLP_RST_MARGIN 4'h0
`define CWLP_RST_HIGH_BYTE 8'hff
`define CWLP_RST_LOW_NIB 4'h0
`define CWLP_RST_DEBOUNCE 4'h0
`define CWLP_RST_LOW_BYTE 8'h00
`define CWLP_RST_PEAK 8'h00
`define CWLP_UNMAPPED_DATA 8'h00

// ----------------------------------------------------------------------------
// Channel numbers
// ----------------------------------------------------------------------------
`define CWLP_CH_PEAK0 3'h0
`define CWLP_CH_PEAK1 3'h1
`define CWLP_CH_WIN6 3'h6
`define CWLP_CH_WIN7 3'h7

`endif

// ===== cwlp_pkg.sv
// Types shared by the window limit and peak tracking block.
// Assumes cwlp_map.svh supplies the numeric constants.
package cwlp_pkg;
    typedef logic [7:0] cwlp_byte_t;
    typedef logic [3:0] cwlp_nib_t;
    typedef logic [11:0] cwlp_code_t;
    typedef logic [2:0] cwlp_chan_t;
    typedef enum logic [1:0] {
        CWLP_INSIDE,
        CWLP_COUNTING,
        CWLP_ALARM
    } cwlp_win_state_t;
endpackage : cwlp_pkg

// ===== cwlp_window_check.sv
// One channel's window comparator with hysteresis and debounce counter.
// Assumes one sample per sample_valid pulse and limits that are stable around it.
`timescale 1ns/100ps
`include "cwlp_map.svh"
module cwlp_window_check #(
    parameter int CODE_W = 12,
    parameter int CNT_W = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sample_valid,
    input wire logic [CODE_W-1:0] code,
    input wire logic [CODE_W-1:0] high_limit,
    input wire logic [CODE_W-1:0] low_limit,
    input wire logic [CNT_W-1:0] margin,
    input wire logic [CNT_W-1:0] debounce,
    output logic event_pulse,
    output logic alarm
);
    import cwlp_pkg::*;

    initial begin
        if (CODE_W < CNT_W + `CWLP_MARGIN_SHIFT + 1 || CNT_W < 1) begin
            $error("cwlp_window_check: CODE_W too small for margin");
        end
    end

    // ------------------------------------------------------------------------
    // Comparisons
    // ------------------------------------------------------------------------
    logic [CODE_W:0] margin_w;
    logic [CODE_W:0] high_clear;
    logic [CODE_W:0] low_clear;
    logic beyond;
    logic settled;

    // Margin sits on the lower seven bits with three zero bits below it.
    assign margin_w = {{(CODE_W-CNT_W-`CWLP_MARGIN_SHIFT+1){1'b0}}, margin,
                       {`CWLP_MARGIN_SHIFT{1'b0}}};
    // Saturate rather than wrap, so a large margin never lifts the high clear point above the high limit.
    assign high_clear = ({1'b0, high_limit} > margin_w) ?
                        {1'b0, high_limit} - margin_w : '0;
    assign low_clear = {1'b0, low_limit} + margin_w;
    assign beyond = (code > high_limit) || (code < low_limit);
    assign settled = ({1'b0, code} <= high_clear) && ({1'b0, code} >= low_clear);

    // ------------------------------------------------------------------------
    // Debounce state machine
    // ------------------------------------------------------------------------
    cwlp_win_state_t state_r;
    logic [CNT_W-1:0] count_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= CWLP_INSIDE;
            count_r <= '0;
            event_pulse <= 1'b0;
        end else begin
            event_pulse <= 1'b0;
            if (sample_valid) begin
                case (state_r)
                    CWLP_INSIDE: begin
                        if (beyond && debounce == '0) begin
                            state_r <= CWLP_ALARM;
                            event_pulse <= 1'b1;
                        end else if (beyond) begin
                            state_r <= CWLP_COUNTING;
                            count_r <= CNT_W'(1);
                        end
                    end
                    CWLP_COUNTING: begin
                        // A debounce value lowered mid-count ends the count instead of wrapping.
                        if (beyond && count_r >= debounce) begin
                            state_r <= CWLP_ALARM;
                            event_pulse <= 1'b1;
                            count_r <= '0;
                        end else if (beyond) begin
                            count_r <= count_r + CNT_W'(1);
                        end else if (settled) begin
                            state_r <= CWLP_INSIDE;
                            count_r <= '0;
                        end
                    end
                    CWLP_ALARM: begin
                        if (settled) begin
                            state_r <= CWLP_INSIDE;
                        end
                    end
                    default: begin
                        state_r <= CWLP_INSIDE;
                        count_r <= '0;
                    end
                endcase
            end
        end
    end

    assign alarm = (state_r == CWLP_ALARM);
endmodule : cwlp_window_check

// ===== cwlp_top.sv
// Limit registers for channels 6 and 7 and peak trackers for channels 0 and 1.
// Assumes a byte-wide register port driven by the serial register host and one-cycle
// conversion strobes from the converter core, both synchronous to clock.
`timescale 1ns/100ps
`include "cwlp_map.svh"
module cwlp_top #(
    parameter int CODE_W = 12,
    parameter int CNT_W = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire cwlp_pkg::cwlp_byte_t reg_wdata,
    input wire logic reg_rd,
    output cwlp_pkg::cwlp_byte_t reg_rdata,
    output logic reg_rdata_valid,
    input wire logic conv_valid,
    input wire cwlp_pkg::cwlp_chan_t conv_channel,
    input wire cwlp_pkg::cwlp_code_t conv_code,
    input wire cwlp_pkg::cwlp_code_t ch6_high_limit,
    input wire cwlp_pkg::cwlp_nib_t ch6_limit_margin,
    output logic [1:0] window_event,
    output logic [1:0] window_alarm,
    output cwlp_pkg::cwlp_code_t ch0_peak_code,
    output cwlp_pkg::cwlp_code_t ch1_peak_code
);
    import cwlp_pkg::*;

    initial begin
        if (CODE_W != 12) begin
            $error("cwlp_top: limit fields only form a 12-bit code");
        end
        if (CNT_W != 4) begin
            $error("cwlp_top: debounce and margin fields are 4 bits");
        end
    end

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // The byte always covers the top of the code and the nibble the bottom.
    function automatic cwlp_code_t make_limit(input cwlp_byte_t upper, input cwlp_nib_t lower);
        make_limit = {upper, lower};
    endfunction : make_limit

    function automatic cwlp_byte_t pack_field(input cwlp_nib_t upper, input cwlp_nib_t lower);
        pack_field = {upper, lower};
    endfunction : pack_field

    // A tracker reads back as its high byte over the upper nibble of its low byte.
    function automatic cwlp_code_t peak_code(input cwlp_byte_t high, input cwlp_byte_t low);
        peak_code = make_limit(high, low[`CWLP_NIB_MSB:`CWLP_NIB_LSB]);
    endfunction : peak_code

    function automatic logic chan_hit(input logic valid, input cwlp_chan_t chan,
                                      input cwlp_chan_t target);
        chan_hit = valid && chan == target;
    endfunction : chan_hit

    // ------------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------------
    logic wr_ch6_lnd;
    logic wr_ch6_lb;
    logic wr_ch7_hnm;
    logic wr_ch7_hb;
    logic wr_ch7_lnd;
    logic wr_ch7_lb;
    logic [1:0] rd_peak_low;
    logic [1:0] rd_peak_high;

    assign wr_ch6_lnd = reg_wr && reg_addr == `CWLP_ADDR_CH6_LOW_NIB_DEB;
    assign wr_ch6_lb = reg_wr && reg_addr == `CWLP_ADDR_CH6_LOW_BYTE;
    assign wr_ch7_hnm = reg_wr && reg_addr == `CWLP_ADDR_CH7_HIGH_NIB_MARGIN;
    assign wr_ch7_hb = reg_wr && reg_addr == `CWLP_ADDR_CH7_HIGH_BYTE;
    assign wr_ch7_lnd = reg_wr && reg_addr == `CWLP_ADDR_CH7_LOW_NIB_DEB;
    assign wr_ch7_lb = reg_wr && reg_addr == `CWLP_ADDR_CH7_LOW_BYTE;
    assign rd_peak_low[0] = reg_rd && reg_addr == `CWLP_ADDR_CH0_PEAK_LOW;
    assign rd_peak_high[0] = reg_rd && reg_addr == `CWLP_ADDR_CH0_PEAK_HIGH;
    assign rd_peak_low[1] = reg_rd && reg_addr == `CWLP_ADDR_CH1_PEAK_LOW;
    assign rd_peak_high[1] = reg_rd && reg_addr == `CWLP_ADDR_CH1_PEAK_HIGH;

    // ------------------------------------------------------------------------
    // Channel 6 low limit and debounce
    // ------------------------------------------------------------------------
    cwlp_nib_t ch6_low_limit_nibble_r;
    cwlp_nib_t ch6_debounce_count_r;
    cwlp_byte_t ch6_low_limit_byte_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ch6_low_limit_nibble_r <= `CWLP_RST_LOW_NIB;
            ch6_debounce_count_r <= `CWLP_RST_DEBOUNCE;
        end else if (wr_ch6_lnd) begin
            ch6_low_limit_nibble_r <= reg_wdata[`CWLP_NIB_MSB:`CWLP_NIB_LSB];
            ch6_debounce_count_r <= reg_wdata[`CWLP_FIELD_MSB:`CWLP_FIELD_LSB];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ch6_low_limit_byte_r <= `CWLP_RST_LOW_BYTE;
        end else if (wr_ch6_lb) begin
            ch6_low_limit_byte_r <= reg_wdata;
        end
    end

    // ------------------------------------------------------------------------
    // Channel 7 high limit and margin
    // ------------------------------------------------------------------------
    cwlp_nib_t ch7_high_limit_nibble_r;
    cwlp_nib_t ch7_limit_margin_r;
    cwlp_byte_t ch7_high_limit_byte_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ch7_high_limit_nibble_r <= `CWLP_RST_HIGH_NIB;
            ch7_limit_margin_r <= `CWLP_RST_MARGIN;
        end else if (wr_ch7_hnm) begin
            ch7_high_limit_nibble_r <= reg_wdata[`CWLP_NIB_MSB:`CWLP_NIB_LSB];
            ch7_limit_margin_r <= reg_wdata[`CWLP_FIELD_MSB:`CWLP_FIELD_LSB];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ch7_high_limit_byte_r <= `CWLP_RST_HIGH_BYTE;
        end else if (wr_ch7_hb) begin
            ch7_high_limit_byte_r <= reg_wdata;
        end
    end

    // ------------------------------------------------------------------------
    // Channel 7 low limit and debounce
    // ------------------------------------------------------------------------
    cwlp_nib_t ch7_low_limit_nibble_r;
    cwlp_nib_t ch7_debounce_count_r;
    cwlp_byte_t ch7_low_limit_byte_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ch7_low_limit_nibble_r <= `CWLP_RST_LOW_NIB;
            ch7_debounce_count_r <= `CWLP_RST_DEBOUNCE;
        end else if (wr_ch7_lnd) begin
            ch7_low_limit_nibble_r <= reg_wdata[`CWLP_NIB_MSB:`CWLP_NIB_LSB];
            ch7_debounce_count_r <= reg_wdata[`CWLP_FIELD_MSB:`CWLP_FIELD_LSB];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ch7_low_limit_byte_r <= `CWLP_RST_LOW_BYTE;
        end else if (wr_ch7_lb) begin
            ch7_low_limit_byte_r <= reg_wdata;
        end
    end

    // ------------------------------------------------------------------------
    // Window comparators
    // ------------------------------------------------------------------------
    logic ch6_sample;
    logic ch7_sample;
    cwlp_code_t ch6_low_limit;
    cwlp_code_t ch7_high_limit;
    cwlp_code_t ch7_low_limit;

    assign ch6_sample = chan_hit(conv_valid, conv_channel, `CWLP_CH_WIN6);
    assign ch7_sample = chan_hit(conv_valid, conv_channel, `CWLP_CH_WIN7);
    assign ch6_low_limit = make_limit(ch6_low_limit_byte_r, ch6_low_limit_nibble_r);
    assign ch7_high_limit = make_limit(ch7_high_limit_byte_r, ch7_high_limit_nibble_r);
    assign ch7_low_limit = make_limit(ch7_low_limit_byte_r, ch7_low_limit_nibble_r);

    cwlp_window_check #(
        .CODE_W(CODE_W),
        .CNT_W(CNT_W)
    ) u_ch6_window (
        .clock(clock),
        .rst_n(rst_n),
        .sample_valid(ch6_sample),
        .code(conv_code),
        // The high limit and margin of this channel arrive as levels from next door.
        .high_limit(ch6_high_limit),
        .low_limit(ch6_low_limit),
        .margin(ch6_limit_margin),
        .debounce(ch6_debounce_count_r),
        .event_pulse(window_event[0]),
        .alarm(window_alarm[0])
    );

    cwlp_window_check #(
        .CODE_W(CODE_W),
        .CNT_W(CNT_W)
    ) u_ch7_window (
        .clock(clock),
        .rst_n(rst_n),
        .sample_valid(ch7_sample),
        .code(conv_code),
        .high_limit(ch7_high_limit),
        .low_limit(ch7_low_limit),
        .margin(ch7_limit_margin_r),
        .debounce(ch7_debounce_count_r),
        .event_pulse(window_event[1]),
        .alarm(window_alarm[1])
    );

    // ------------------------------------------------------------------------
    // Peak trackers
    // ------------------------------------------------------------------------
    // The high byte holds code bits 11:4 and the low byte holds bits 3:0 in its
    // upper nibble, matching the alignment of the limit registers. Each byte clears
    // on its own read, so a partly cleared tracker compares against what remains.
    cwlp_byte_t peak_high_r [2];
    cwlp_byte_t peak_low_r [2];
    logic [1:0] peak_sample;
    logic [1:0] peak_load;

    assign peak_sample[0] = chan_hit(conv_valid, conv_channel, `CWLP_CH_PEAK0);
    assign peak_sample[1] = chan_hit(conv_valid, conv_channel, `CWLP_CH_PEAK1);

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            peak_load[i] = peak_sample[i] &&
                (conv_code > peak_code(peak_high_r[i], peak_low_r[i]));
        end
    end

    // A new larger code in the cycle of a read wins over the clear, so no peak is lost.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 2; i++) begin
                peak_high_r[i] <= `CWLP_RST_PEAK;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (peak_load[i]) begin
                    peak_high_r[i] <= conv_code[11:4];
                end else if (rd_peak_high[i]) begin
                    peak_high_r[i] <= `CWLP_RST_PEAK;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 2; i++) begin
                peak_low_r[i] <= `CWLP_RST_PEAK;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (peak_load[i]) begin
                    peak_low_r[i] <= pack_field(conv_code[3:0], 4'h0);
                end else if (rd_peak_low[i]) begin
                    peak_low_r[i] <= `CWLP_RST_PEAK;
                end
            end
        end
    end

    assign ch0_peak_code = peak_code(peak_high_r[0], peak_low_r[0]);
    assign ch1_peak_code = peak_code(peak_high_r[1], peak_low_r[1]);

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    cwlp_byte_t read_mux;

    always_comb begin
        case (reg_addr)
            `CWLP_ADDR_CH6_LOW_NIB_DEB:
                read_mux = pack_field(ch6_low_limit_nibble_r, ch6_debounce_count_r);
            `CWLP_ADDR_CH6_LOW_BYTE: read_mux = ch6_low_limit_byte_r;
            `CWLP_ADDR_CH7_HIGH_NIB_MARGIN:
                read_mux = pack_field(ch7_high_limit_nibble_r, ch7_limit_margin_r);
            `CWLP_ADDR_CH7_HIGH_BYTE: read_mux = ch7_high_limit_byte_r;
            `CWLP_ADDR_CH7_LOW_NIB_DEB:
                read_mux = pack_field(ch7_low_limit_nibble_r, ch7_debounce_count_r);
            `CWLP_ADDR_CH7_LOW_BYTE: read_mux = ch7_low_limit_byte_r;
            `CWLP_ADDR_CH0_PEAK_LOW: read_mux = peak_low_r[0];
            `CWLP_ADDR_CH0_PEAK_HIGH: read_mux = peak_high_r[0];
            `CWLP_ADDR_CH1_PEAK_LOW: read_mux = peak_low_r[1];
            `CWLP_ADDR_CH1_PEAK_HIGH: read_mux = peak_high_r[1];
            default: read_mux = `CWLP_UNMAPPED_DATA;
        endcase
    end

    // Read data is captured from the value before any clear in the same edge.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `CWLP_UNMAPPED_DATA;
        end else if (reg_rd) begin
            reg_rdata <= read_mux;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_valid <= 1'b0;
        end else begin
            reg_rdata_valid <= reg_rd;
        end
    end
endmodule : cwlp_top

// ===== cwlp_asserts.sv
// Port checker for the window limit and peak tracking block.
// Assumes it is bound into cwlp_top and sees only the top module's ports.
`timescale 1ns/100ps
module cwlp_asserts #(
    parameter int CODE_W = 12,
    parameter int CNT_W = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire cwlp_pkg::cwlp_byte_t reg_rdata,
    input wire logic reg_rdata_valid,
    input wire logic conv_valid,
    input wire cwlp_pkg::cwlp_chan_t conv_channel,
    input wire cwlp_pkg::cwlp_code_t conv_code,
    input wire logic [1:0] window_event,
    input wire logic [1:0] window_alarm,
    input wire cwlp_pkg::cwlp_code_t ch0_peak_code,
    input wire cwlp_pkg::cwlp_code_t ch1_peak_code
);
    import cwlp_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    property p_rd_valid; reg_rd |=> reg_rdata_valid; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
    property p_valid_cause; reg_rdata_valid |-> $past(reg_rd); endproperty
    a_valid_cause: assert property (p_valid_cause) else $error("answer without read");
    property p_hi_data; reg_rd && reg_addr == 8'h61 |=> reg_rdata == $past(ch0_peak_code[11:4]);
    endproperty
    a_hi_data: assert property (p_hi_data) else $error("peak byte read wrong");
    property p_hi_clr; reg_rd && reg_addr == 8'h61 && !(conv_valid && conv_channel == 3'h0)
        |=> ch0_peak_code[11:4] == 8'h00; endproperty
    a_hi_clr: assert property (p_hi_clr) else $error("peak byte not cleared");
    property p_keep; !(reg_rd && reg_addr[7:1] == 7'h30) |=> ch0_peak_code >= $past(ch0_peak_code);
    endproperty
    a_keep: assert property (p_keep) else $error("peak dropped without read");
    property p_load; conv_valid && conv_channel == 3'h0 && conv_code > ch0_peak_code
        |=> ch0_peak_code == $past(conv_code); endproperty
    a_load: assert property (p_load) else $error("larger code not loaded");
    property p_load1; conv_valid && conv_channel == 3'h1 && !reg_rd
        |=> ch1_peak_code >= $past(conv_code); endproperty
    a_load1: assert property (p_load1) else $error("peak below last code");
    property p_ev_rise; window_event[1] |-> $rose(window_alarm[1]); endproperty
    a_ev_rise: assert property (p_ev_rise) else $error("event without alarm rise");
    property p_ev_one; window_event[0] |=> !window_event[0]; endproperty
    a_ev_one: assert property (p_ev_one) else $error("event longer than a cycle");
    property p_cause; $changed(window_alarm)
        |-> $past(conv_valid) || $past(conv_valid, 2) || $past(conv_valid, 3); endproperty
    a_cause: assert property (p_cause) else $error("alarm moved without sample");
    c_ev: cover property (window_event[1]);
    c_clr: cover property (reg_rd && reg_addr == 8'h61 && ch0_peak_code != 12'h000);
    c_fall: cover property ($fell(window_alarm[1]));
endmodule : cwlp_asserts

bind cwlp_top cwlp_asserts #(.CODE_W(CODE_W), .CNT_W(CNT_W)) u_asserts (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid), .conv_valid(conv_valid),
    .conv_channel(conv_channel), .conv_code(conv_code), .window_event(window_event),
    .window_alarm(window_alarm), .ch0_peak_code(ch0_peak_code), .ch1_peak_code(ch1_peak_code)
);

// ===== cwlp_host_model.sv
// Host model: register host and converter result source for cwlp_top.
// Assumes one task call at a time, started after reset release.
`timescale 1ns/100ps
module cwlp_host_model (
    input wire logic clock,
    input wire cwlp_pkg::cwlp_byte_t reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output cwlp_pkg::cwlp_byte_t reg_wdata,
    output logic reg_rd,
    output logic conv_valid,
    output cwlp_pkg::cwlp_chan_t conv_channel,
    output cwlp_pkg::cwlp_code_t conv_code
);
    import cwlp_pkg::*;
    initial begin
        {reg_addr, reg_wr, reg_wdata, reg_rd} = 18'h0;
        {conv_valid, conv_channel, conv_code} = 16'h0;
    end
    // Released address, data, channel and code lines flip to the inverse of their last
    // value and the strobes drop low, so a stale address or code can never pass for a fresh one.
    task automatic xfer(input logic w, input logic [7:0] a, input cwlp_byte_t d,
                        output cwlp_byte_t q);
        @(posedge clock);
        #1;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
        @(posedge clock);
        #1;
        q = reg_rdata;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = {~a, ~d, 2'b00};
    endtask : xfer
    task automatic conv(input cwlp_chan_t ch, input cwlp_code_t c);
        @(posedge clock);
        #1;
        {conv_channel, conv_code, conv_valid} = {ch, c, 1'b1};
        @(posedge clock);
        #1;
        {conv_channel, conv_code, conv_valid} = {~ch, ~c, 1'b0};
    endtask : conv
endmodule : cwlp_host_model

// ===== cwlp_top_tb.sv
// Self-checking testbench for cwlp_top, driven through the host model.
// Assumes a 20 MHz clock; the ch6 limit inputs are held as levels here.
`timescale 1ns/100ps
module cwlp_top_tb;
    import cwlp_pkg::*;
    logic clock, rst_n, reg_wr, reg_rd, reg_rdata_valid, conv_valid;
    logic [7:0] reg_addr;
    logic [1:0] window_event, window_alarm;
    cwlp_byte_t reg_wdata, reg_rdata, junk;
    cwlp_chan_t conv_channel;
    cwlp_code_t conv_code, ch6_high_limit, ch0_peak_code, ch1_peak_code;
    cwlp_nib_t ch6_limit_margin;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    int ev6 = 0;
    int ev7 = 0;
    logic [7:0] ra [10] = '{8'h3a,8'h3b,8'h3c,8'h3d,8'h3e,8'h3f,8'h60,8'h61,8'h62,8'h63};
    logic [7:0] rv [10] = '{8'h00,8'h00,8'hf0,8'hff,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00};
    cwlp_top uut (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rdata_valid(reg_rdata_valid), .conv_valid(conv_valid),
        .conv_channel(conv_channel), .conv_code(conv_code), .ch6_high_limit(ch6_high_limit),
        .ch6_limit_margin(ch6_limit_margin), .window_event(window_event),
        .window_alarm(window_alarm), .ch0_peak_code(ch0_peak_code), .ch1_peak_code(ch1_peak_code)
    );
    cwlp_host_model host (
        .clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .conv_valid(conv_valid),
        .conv_channel(conv_channel), .conv_code(conv_code)
    );
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // The whole run needs about 135 cycles; the ceiling leaves ample slack.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        ev6 <= ev6 + (window_event[0] === 1'b1);
        ev7 <= ev7 + (window_event[1] === 1'b1);
        if (cycles == 3000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        cwlp_byte_t d;
        host.xfer(1'b0, a, 8'h00, d);
        chk({4'h0, d}, {4'h0, exp});
        chk({11'h0, reg_rdata_valid}, 12'h001);
    endtask : rdchk
    // One sample, then one settling cycle before both alarm levels are judged.
    task automatic cchk(input cwlp_chan_t ch, input cwlp_code_t c, input logic [1:0] exp);
        host.conv(ch, c);
        @(posedge clock);
        #1;
        chk({10'h0, window_alarm}, {10'h0, exp});
    endtask : cchk
    task automatic t_regs();
        for (int i = 0; i < 10; i++) begin
            rdchk(ra[i], rv[i]);
        end
        rdchk(8'h40, 8'h00);
        for (int i = 0; i < 6; i++) begin
            host.xfer(1'b1, ra[i], ra[i] ^ 8'h96, junk);
            rdchk(ra[i], ra[i] ^ 8'h96);
        end
        host.xfer(1'b1, 8'h60, 8'h77, junk);
        rdchk(8'h60, 8'h00);
    endtask : t_regs
    task automatic t_peak();
        host.conv(3'h0, 12'h123);
        host.conv(3'h0, 12'h456);
        host.conv(3'h0, 12'h200);
        host.conv(3'h1, 12'habc);
        host.conv(3'h3, 12'hfff);
        chk(ch0_peak_code, 12'h456);
        chk(ch1_peak_code, 12'habc);
        rdchk(8'h61, 8'h45);
        rdchk(8'h61, 8'h00);
        chk(ch0_peak_code, 12'h006);
        rdchk(8'h60, 8'h60);
        rdchk(8'h60, 8'h00);
        rdchk(8'h63, 8'hab);
        rdchk(8'h62, 8'hc0);
    endtask : t_peak
    task automatic t_window();
        host.xfer(1'b1, 8'h3b, 8'h10, junk);
        host.xfer(1'b1, 8'h3a, 8'h01, junk);
        cchk(3'h6, 12'h301, 2'b00);
        cchk(3'h6, 12'h301, 2'b01);
        cchk(3'h6, 12'h2f9, 2'b01);
        cchk(3'h6, 12'h2f8, 2'b00);
        cchk(3'h6, 12'h0ff, 2'b00);
        cchk(3'h6, 12'h0ff, 2'b01);
        cchk(3'h6, 12'h108, 2'b00);
        chk(ev6[11:0], 12'h002);
        host.xfer(1'b1, 8'h3c, 8'h52, junk);
        host.xfer(1'b1, 8'h3d, 8'h80, junk);
        host.xfer(1'b1, 8'h3e, 8'h32, junk);
        host.xfer(1'b1, 8'h3f, 8'h20, junk);
        cchk(3'h7, 12'h805, 2'b00);
        cchk(3'h7, 12'h806, 2'b00);
        cchk(3'h7, 12'h806, 2'b00);
        cchk(3'h7, 12'h806, 2'b10);
        cchk(3'h7, 12'h7f6, 2'b10);
        cchk(3'h7, 12'h7f5, 2'b00);
        host.xfer(1'b1, 8'h3e, 8'h30, junk);
        cchk(3'h7, 12'h202, 2'b10);
        cchk(3'h7, 12'h213, 2'b00);
        chk(ev7[11:0], 12'h002);
    endtask : t_window
    initial begin
        rst_n = 1'b0;
        ch6_high_limit = 12'h300;
        ch6_limit_margin = 4'h1;
        repeat (2) @(posedge clock);
        #1;
        rst_n = 1'b1;
        t_regs();
        t_peak();
        t_window();
        report_and_stop();
    end
endmodule : cwlp_top_tb
